// >>> pkg/spc_pkg.sv
// Constants shared by the sampling loop control block
`default_nettype none
package spc_pkg;
	// ***********************************
	// Timing
	// ***********************************
	localparam int PCLK_PERIOD_NS = 25;
	localparam int CAL_TIME_NS = 100000;
	localparam int CAL_CYCLES = (CAL_TIME_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
	localparam int CAL_CNT_W = 12;
	localparam logic [CAL_CNT_W-1:0] CAL_LAST = CAL_CNT_W'(CAL_CYCLES - 1);

	// ***********************************
	// Register indices (byte address is four times the index)
	// ***********************************
	localparam logic [7:0] IDX_SOFT_RESET = 8'h00;
	localparam logic [7:0] IDX_CLK_SOURCE = 8'h53;
	localparam logic [7:0] IDX_REF_DIV_LO = 8'h54;
	localparam logic [7:0] IDX_REF_DIV_HI = 8'h55;
	localparam logic [7:0] IDX_FB_DIV_LO = 8'h56;
	localparam logic [7:0] IDX_FB_DIV_HI = 8'h57;
	localparam logic [7:0] IDX_PUMP = 8'h58;
	localparam logic [7:0] IDX_EN_A = 8'h59;
	localparam logic [7:0] IDX_FILT_RES = 8'h5a;
	localparam logic [7:0] IDX_CAP_THREE = 8'h5b;
	localparam logic [7:0] IDX_CAP_ONE = 8'h5c;
	localparam logic [7:0] IDX_CAP_TWO = 8'h5d;
	localparam logic [7:0] IDX_EN_B = 8'h5f;
	localparam logic [7:0] IDX_CAL_TRIG = 8'h6b;
	localparam logic [7:0] IDX_OUT_CLK = 8'h6d;
	localparam logic [7:0] IDX_STATUS = 8'hd1;
	localparam logic [7:0] IDX_IRQ_STAT = 8'he0;
	localparam logic [7:0] IDX_IRQ_MASK = 8'he1;

	// ***********************************
	// Field positions
	// ***********************************
	localparam int OUT_DIV_LSB = 4;
	localparam int EN_LOOP_BIT = 0;
	localparam int EN_REFDIV_BIT = 1;
	localparam int EN_OUT_BIT = 0;
	localparam int EN_BIAS_BIT = 1;
	localparam int OUT_CLK_EN_BIT = 0;
	localparam int DELAY_LSB = 1;
	localparam int STAT_CAL_BIT = 0;
	localparam int STAT_LOW_BIT = 1;
	localparam int STAT_HIGH_BIT = 2;
	localparam int EV_CAL = 0;
	localparam int EV_LOW = 1;
	localparam int EV_HIGH = 2;

	// ***********************************
	// Reset values
	// ***********************************
	localparam logic [9:0] RST_REF_DIV = 10'h001;
	localparam logic [11:0] RST_FB_DIV = 12'h001;
	localparam logic [3:0] RST_OUT_DIV = 4'h1;
	localparam logic [3:0] RST_PUMP = 4'h0;
	localparam logic [4:0] RST_FILT = 5'h00;
	localparam logic [2:0] RST_MASK = 3'h0;
endpackage
`default_nettype wire

// >>> logic/spc_cal_seq.sv
// Calibration sequencer: runs one timed calibration per start pulse
`default_nettype none
module spc_cal_seq (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	output logic busy,
	output logic done
);
	logic [spc_pkg::CAL_CNT_W-1:0] cnt_ff;
	logic busy_ff;

	// A new start while busy restarts the timer, so the last setting wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_ff <= 1'b0;
			cnt_ff <= '0;
		end else if (start) begin
			busy_ff <= 1'b1;
			cnt_ff <= '0;
		end else if (busy_ff) begin
			if (cnt_ff == spc_pkg::CAL_LAST) begin
				busy_ff <= 1'b0;
			end else begin
				cnt_ff <= cnt_ff + 1'b1;
			end
		end
	end

	assign done = busy_ff & (cnt_ff == spc_pkg::CAL_LAST) & ~start;
	assign busy = busy_ff;

	start_to_busy_a: assert property (
		@(posedge pclk) disable iff (!presetn) start |=> busy ##1 busy)
		else $error("calibration did not go busy after start");

	done_ends_busy_a: assert property (
		@(posedge pclk) disable iff (!presetn) done |-> busy ##1 !busy)
		else $error("calibration done without ending busy");
endmodule
`default_nettype wire

// >>> logic/spc_pll_ctrl.sv
// Register, enable and calibration control for the sampling clock loop
//
// The APB interface to the registers was decided locally.
`default_nettype none
module spc_pll_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [9:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic osc_low_drift_flag,
	input wire logic osc_high_drift_flag,
	output logic [9:0] reference_divider,
	output logic [11:0] feedback_divider,
	output logic [3:0] output_divider,
	output logic [3:0] pump_current_code,
	output logic [4:0] filter_resistor_code,
	output logic [4:0] filter_cap_one_code,
	output logic [4:0] filter_cap_two_code,
	output logic [4:0] filter_cap_three_code,
	output logic loop_enable,
	output logic ref_divider_enable,
	output logic loop_out_enable,
	output logic loop_bias_enable,
	output logic loop_clk_route_en,
	output logic [2:0] out_clock_delay,
	output logic sample_from_loop,
	output logic soft_reset_active,
	output logic cal_run
);
	// *******************************************
	// Bus decode
	// *******************************************
	logic [7:0] idx;
	logic setup;
	logic access;
	logic hit;
	logic wr_en;
	logic [7:0] rd_byte;

	logic [9:0] ref_div_ff;
	logic [11:0] fb_div_ff;
	logic [3:0] out_div_ff;
	logic [3:0] pump_ff;
	logic [4:0] res_ff;
	logic [4:0] cap1_ff;
	logic [4:0] cap2_ff;
	logic [4:0] cap3_ff;
	logic [1:0] en_a_ff;
	logic [1:0] en_b_ff;
	logic [3:0] out_clk_ff;
	logic src_ff;
	logic soft_ff;
	logic trig_ff;
	logic trig_prev_ff;
	logic soft_prev_ff;
	logic cal_stat_ff;
	logic [2:0] mask_ff;
	logic [2:0] irq_stat_ff;
	logic [2:0] irq_clr;
	logic [2:0] ev;
	logic low_s1_ff;
	logic low_s2_ff;
	logic high_s1_ff;
	logic high_s2_ff;
	logic low_prev_ff;
	logic high_prev_ff;
	logic [31:0] prdata_ff;
	logic cal_start;
	logic cal_busy;
	logic cal_done;

	// Zero divide codes would stall the dividers, so they act as one
	function automatic logic [11:0] div_nz(input logic [11:0] v);
		div_nz = (v == 12'h000) ? 12'h001 : v;
	endfunction

	// Zero-wait slave; word aligned, lane 0 carries the byte
	assign idx = paddr[9:2];
	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign pready = 1'b1;
	assign pslverr = access & ~hit;
	assign wr_en = access & pwrite & pstrb[0] & hit;
	assign prdata = prdata_ff;

	always_comb begin
		rd_byte = 8'h00;
		hit = (paddr[1:0] == 2'b00);
		unique case (idx)
			spc_pkg::IDX_SOFT_RESET: rd_byte = {7'h00, soft_ff};
			spc_pkg::IDX_CLK_SOURCE: rd_byte = {7'h00, src_ff};
			spc_pkg::IDX_REF_DIV_LO: rd_byte = ref_div_ff[7:0];
			spc_pkg::IDX_REF_DIV_HI: rd_byte = {out_div_ff, 2'b00, ref_div_ff[9:8]};
			spc_pkg::IDX_FB_DIV_LO: rd_byte = fb_div_ff[7:0];
			spc_pkg::IDX_FB_DIV_HI: rd_byte = {4'h0, fb_div_ff[11:8]};
			spc_pkg::IDX_PUMP: rd_byte = {4'h0, pump_ff};
			spc_pkg::IDX_EN_A: rd_byte = {6'h00, en_a_ff};
			spc_pkg::IDX_FILT_RES: rd_byte = {3'h0, res_ff};
			spc_pkg::IDX_CAP_THREE: rd_byte = {3'h0, cap3_ff};
			spc_pkg::IDX_CAP_ONE: rd_byte = {3'h0, cap1_ff};
			spc_pkg::IDX_CAP_TWO: rd_byte = {3'h0, cap2_ff};
			spc_pkg::IDX_EN_B: rd_byte = {6'h00, en_b_ff};
			spc_pkg::IDX_CAL_TRIG: rd_byte = {7'h00, trig_ff};
			spc_pkg::IDX_OUT_CLK: rd_byte = {4'h0, out_clk_ff};
			spc_pkg::IDX_STATUS: rd_byte = {5'h00, high_s2_ff, low_s2_ff, cal_stat_ff};
			spc_pkg::IDX_IRQ_STAT: rd_byte = {5'h00, irq_stat_ff};
			spc_pkg::IDX_IRQ_MASK: rd_byte = {5'h00, mask_ff};
			default: hit = 1'b0;
		endcase
	end

	// Read data is captured in the setup cycle and held for the access edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0000_0000;
		end else if (setup & ~pwrite) begin
			prdata_ff <= {24'h00_0000, rd_byte};
		end
	end

	// *******************************************
	// Configuration registers
	// *******************************************
	// config holds until rewritten
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_div_ff <= spc_pkg::RST_REF_DIV;
			fb_div_ff <= spc_pkg::RST_FB_DIV;
			out_div_ff <= spc_pkg::RST_OUT_DIV;
			pump_ff <= spc_pkg::RST_PUMP;
			res_ff <= spc_pkg::RST_FILT;
			cap1_ff <= spc_pkg::RST_FILT;
			cap2_ff <= spc_pkg::RST_FILT;
			cap3_ff <= spc_pkg::RST_FILT;
			en_a_ff <= 2'b00;
			en_b_ff <= 2'b00;
			out_clk_ff <= 4'h0;
			src_ff <= 1'b0;
			soft_ff <= 1'b0;
			trig_ff <= 1'b0;
			mask_ff <= spc_pkg::RST_MASK;
		end else if (wr_en) begin
			unique case (idx)
				spc_pkg::IDX_SOFT_RESET: soft_ff <= pwdata[0];
				spc_pkg::IDX_CLK_SOURCE: src_ff <= pwdata[0];
				spc_pkg::IDX_REF_DIV_LO: ref_div_ff[7:0] <= pwdata[7:0];
				spc_pkg::IDX_REF_DIV_HI: begin
					ref_div_ff[9:8] <= pwdata[1:0];
					out_div_ff <= pwdata[spc_pkg::OUT_DIV_LSB +: 4];
				end
				spc_pkg::IDX_FB_DIV_LO: fb_div_ff[7:0] <= pwdata[7:0];
				spc_pkg::IDX_FB_DIV_HI: fb_div_ff[11:8] <= pwdata[3:0];
				spc_pkg::IDX_PUMP: pump_ff <= pwdata[3:0];
				spc_pkg::IDX_EN_A: en_a_ff <= pwdata[1:0];
				spc_pkg::IDX_FILT_RES: res_ff <= pwdata[4:0];
				spc_pkg::IDX_CAP_THREE: cap3_ff <= pwdata[4:0];
				spc_pkg::IDX_CAP_ONE: cap1_ff <= pwdata[4:0];
				spc_pkg::IDX_CAP_TWO: cap2_ff <= pwdata[4:0];
				spc_pkg::IDX_EN_B: en_b_ff <= pwdata[1:0];
				spc_pkg::IDX_CAL_TRIG: trig_ff <= pwdata[0];
				spc_pkg::IDX_OUT_CLK: out_clk_ff <= pwdata[3:0];
				spc_pkg::IDX_IRQ_MASK: mask_ff <= pwdata[2:0];
				default: ;
			endcase
		end
	end

	// reference divide code prescaler code ratio set by codes
	assign reference_divider = 10'(div_nz({2'b00, ref_div_ff}));
	assign feedback_divider = div_nz(fb_div_ff);
	assign output_divider = 4'(div_nz({8'h00, out_div_ff}));
	assign pump_current_code = pump_ff;
	assign filter_resistor_code = res_ff;
	assign filter_cap_one_code = cap1_ff;
	assign filter_cap_two_code = cap2_ff;
	assign filter_cap_three_code = cap3_ff;
	assign loop_enable = en_a_ff[spc_pkg::EN_LOOP_BIT];
	assign ref_divider_enable = en_a_ff[spc_pkg::EN_REFDIV_BIT];
	assign loop_out_enable = en_b_ff[spc_pkg::EN_OUT_BIT];
	assign loop_bias_enable = en_b_ff[spc_pkg::EN_BIAS_BIT];
	assign loop_clk_route_en = out_clk_ff[spc_pkg::OUT_CLK_EN_BIT];
	assign out_clock_delay = out_clk_ff[spc_pkg::DELAY_LSB +: 3];
	assign sample_from_loop = src_ff;
	assign soft_reset_active = soft_ff;

	// *******************************************
	// Calibration
	// *******************************************
	// Edge history of trigger and soft reset bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_prev_ff <= 1'b0;
			soft_prev_ff <= 1'b0;
		end else begin
			trig_prev_ff <= trig_ff;
			soft_prev_ff <= soft_ff;
		end
	end

	// trigger rise starts soft reset exit starts
	assign cal_start = (trig_ff & ~trig_prev_ff) | (~soft_ff & soft_prev_ff);

	spc_cal_seq u_cal (
		.pclk(pclk),
		.presetn(presetn),
		.start(cal_start),
		.busy(cal_busy),
		.done(cal_done)
	);
	assign cal_run = cal_busy;

	// status bit busy/done cleared on start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cal_stat_ff <= 1'b0;
		end else if (cal_start) begin
			cal_stat_ff <= 1'b0;
		end else if (cal_done) begin
			cal_stat_ff <= 1'b1;
		end
	end

	// *******************************************
	// Drift flags and interrupts
	// *******************************************
	// drift flag synchronisers, flags come from the analog loop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_s1_ff <= 1'b0;
			low_s2_ff <= 1'b0;
			high_s1_ff <= 1'b0;
			high_s2_ff <= 1'b0;
			low_prev_ff <= 1'b0;
			high_prev_ff <= 1'b0;
		end else begin
			low_s1_ff <= osc_low_drift_flag;
			low_s2_ff <= low_s1_ff;
			high_s1_ff <= osc_high_drift_flag;
			high_s2_ff <= high_s1_ff;
			low_prev_ff <= low_s2_ff;
			high_prev_ff <= high_s2_ff;
		end
	end

	assign ev[spc_pkg::EV_CAL] = cal_done;
	assign ev[spc_pkg::EV_LOW] = low_s2_ff & ~low_prev_ff;
	assign ev[spc_pkg::EV_HIGH] = high_s2_ff & ~high_prev_ff;

	// Only bits already shown to software are cleared, so a new event survives
	assign irq_clr = (access & ~pwrite & (idx == spc_pkg::IDX_IRQ_STAT)) ? prdata_ff[2:0] : 3'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_ff <= 3'h0;
		end else begin
			irq_stat_ff <= (irq_stat_ff & ~irq_clr) | ev;
		end
	end

	assign irq = |(irq_stat_ff & mask_ff);

	// *******************************************
	// Checks
	// *******************************************
	trig_rise_cal_a: assert property (
		@(posedge pclk) disable iff (!presetn) $rose(trig_ff) |=> cal_busy)
		else $error("trigger rise did not start calibration");

	soft_exit_cal_a: assert property (
		@(posedge pclk) disable iff (!presetn) $fell(soft_ff) |=> cal_busy && !cal_stat_ff)
		else $error("soft reset exit did not start calibration");

	stat_busy_a: assert property (
		@(posedge pclk) disable iff (!presetn) cal_busy |-> !cal_stat_ff)
		else $error("calibration status shows done while busy");

	stat_done_a: assert property (
		@(posedge pclk) disable iff (!presetn) cal_done && !cal_start |=> cal_stat_ff)
		else $error("calibration status not done after finish");

	drift_low_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		osc_low_drift_flag [*3] |-> low_s2_ff)
		else $error("low drift flag not visible after two stages");

	route_gate_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr_en && idx == spc_pkg::IDX_OUT_CLK && !pwdata[0] |=> !loop_clk_route_en)
		else $error("loop clock still routed after disable");

	no_auto_cal_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr_en && idx >= spc_pkg::IDX_REF_DIV_LO && idx <= spc_pkg::IDX_FB_DIV_HI
		&& !cal_busy && !cal_start |=> !cal_busy)
		else $error("divider write started a calibration");

	ref_div_nz_a: assert property (
		@(posedge pclk) disable iff (!presetn) reference_divider != 10'h000)
		else $error("reference divide code is zero");
endmodule
`default_nettype wire

// >>> testbench/spc_loop_model.sv
// Drift flag source standing in for the analog loop
`default_nettype none
module spc_loop_model (
	input wire logic pclk,
	input wire logic low_req,
	input wire logic high_req,
	output logic low_flag,
	output logic high_flag
);
	timeunit 1ns;
	timeprecision 100ps;
	// Flags start quiet so the synchroniser never sees an unknown
	initial begin
		low_flag = 1'b0;
		high_flag = 1'b0;
	end
	always @(posedge pclk) begin
		low_flag <= low_req;
		high_flag <= high_req;
	end
endmodule
`default_nettype wire

// >>> testbench/spc_pll_ctrl_bench.sv
// Self-checking bench for the sampling loop control block
`default_nettype none
module spc_pll_ctrl_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic pclk, presetn, psel, penable, pwrite, low_req, high_req, lo_f, hi_f, er;
	logic pready, pslverr, irq, loop_enable, ref_divider_enable, loop_out_enable;
	logic loop_bias_enable, loop_clk_route_en, sample_from_loop, soft_reset_active, cal_run;
	logic [9:0] paddr, reference_divider;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb, output_divider, pump_current_code;
	logic [11:0] feedback_divider;
	logic [4:0] filter_resistor_code, filter_cap_one_code, filter_cap_two_code;
	logic [4:0] filter_cap_three_code;
	logic [2:0] out_clock_delay;
	logic [7:0] mdl [256];
	logic [7:0] cfg [14] = '{8'h53, 8'h54, 8'h55, 8'h56, 8'h57, 8'h58, 8'h59, 8'h5a,
		8'h5b, 8'h5c, 8'h5d, 8'h5f, 8'h6d, 8'he1};
	int err_total, checks, seed, cyc;
	realtime t0;

	spc_pll_ctrl dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .irq, .osc_low_drift_flag(lo_f),
		.osc_high_drift_flag(hi_f), .reference_divider, .feedback_divider, .output_divider,
		.pump_current_code, .filter_resistor_code, .filter_cap_one_code,
		.filter_cap_two_code, .filter_cap_three_code, .loop_enable, .ref_divider_enable,
		.loop_out_enable, .loop_bias_enable, .loop_clk_route_en, .out_clock_delay,
		.sample_from_loop, .soft_reset_active, .cal_run);
	spc_loop_model loop_m (.pclk, .low_req, .high_req, .low_flag(lo_f), .high_flag(hi_f));

	// ************
	// Helpers
	// ************
	// Writable bits per index; unused bits are expected to read back as zero
	function automatic logic [7:0] wmask(input logic [7:0] i);
		case (i)
			8'h00, 8'h53, 8'h6b: wmask = 8'h01;
			8'h55: wmask = 8'hf3;
			8'h57, 8'h58, 8'h6d: wmask = 8'h0f;
			8'h59, 8'h5f: wmask = 8'h03;
			8'h5a, 8'h5b, 8'h5c, 8'h5d: wmask = 8'h1f;
			8'he1: wmask = 8'h07;
			default: wmask = 8'hff;
		endcase
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One APB transfer; returns at the edge where pready is sampled high
	task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= {i, 2'b00};
		pwrite <= w;
		pwdata <= {24'($random(seed)), d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (w && er === 1'b0 && i != 8'hd1 && pstrb[0]) mdl[i] = d & wmask(i);
	endtask

	task automatic ports_chk;
		logic [9:0] r;
		logic [11:0] n;
		logic [3:0] o;
		r = {mdl[8'h55][1:0], mdl[8'h54]};
		n = {mdl[8'h57][3:0], mdl[8'h56]};
		o = mdl[8'h55][7:4];
		chk(32'(reference_divider), 32'(r == 0 ? 10'h001 : r));
		chk(32'(feedback_divider), 32'(n == 0 ? 12'h001 : n));
		chk(32'(output_divider), 32'(o == 0 ? 4'h1 : o));
		chk(32'({pump_current_code, filter_resistor_code, filter_cap_one_code,
			filter_cap_two_code, filter_cap_three_code}), 32'({mdl[8'h58][3:0],
			mdl[8'h5a][4:0], mdl[8'h5c][4:0], mdl[8'h5d][4:0], mdl[8'h5b][4:0]}));
		chk(32'({loop_enable, ref_divider_enable, loop_out_enable, loop_bias_enable}),
			32'({mdl[8'h59][0], mdl[8'h59][1], mdl[8'h5f][0], mdl[8'h5f][1]}));
		chk(32'({loop_clk_route_en, out_clock_delay, sample_from_loop}),
			32'({mdl[8'h6d][0], mdl[8'h6d][3:1], mdl[8'h53][0]}));
	endtask

	// Start latency, busy span, done flag and interrupt of one calibration
	task automatic cal_chk;
		cyc = 0;
		while (cal_run !== 1'b1 && cyc < 10) begin
			@(posedge pclk);
			#1;
			cyc++;
		end
		chk(32'(cyc), 32'd1);
		t0 = $realtime;
		apb(1'b0, 8'hd1, 8'h00);
		chk(32'(rd[0]), 32'h0);
		while (cal_run === 1'b1 && cyc < 5000) begin
			@(posedge pclk);
			#1;
			cyc++;
		end
		chk(32'(int'(($realtime - t0) / 25.0)), 32'(spc_pkg::CAL_CYCLES));
		chk(32'(irq), 32'h1);
		apb(1'b0, 8'hd1, 8'h00);
		chk(rd, 32'h1);
		apb(1'b0, 8'he0, 8'h00);
		chk(rd, 32'h1);
		#1;
		chk(32'(irq), 32'h0);
	endtask

	task automatic finish_test;
		$display("Checks %0d, errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ************
	// Clock and watchdog
	// ************
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	// Two calibrations plus traffic, about 8500 cycles; over four times that for margin
	initial begin
		#(40000 * 25);
		err_total++;
		finish_test;
	end

	// ************
	// Main sequence
	// ************
	initial begin
		seed = 99;
		{presetn, psel, penable, pwrite, low_req, high_req} = 6'h00;
		paddr = 10'h000;
		pwdata = 32'h0;
		pstrb = 4'h1;
		foreach (mdl[k]) mdl[k] = 8'h00;
		mdl[8'h54] = 8'h01;
		mdl[8'h55] = 8'h10;
		mdl[8'h56] = 8'h01;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		ports_chk;
		chk(32'(cal_run), 32'h0);
		foreach (cfg[k]) begin
			apb(1'b0, cfg[k], 8'h00);
			chk(rd, 32'(mdl[cfg[k]]));
		end
		apb(1'b1, 8'he1, 8'h01);
		apb(1'b1, 8'h00, 8'h01);
		// The write lands at the edge the task returns on, so look just after it
		#1;
		chk(32'(soft_reset_active), 32'h1);
		apb(1'b1, 8'h00, 8'h00);
		cal_chk;
		repeat (3) begin
			foreach (cfg[k]) begin
				apb(1'b1, cfg[k], 8'($random(seed)));
				apb(1'b0, cfg[k], 8'h00);
				chk(rd, 32'(mdl[cfg[k]]));
			end
			ports_chk;
		end
		apb(1'b1, 8'he1, 8'h01);
		foreach (cfg[k]) apb(1'b1, cfg[k], 8'h00);
		ports_chk;
		chk(32'(cal_run), 32'h0);
		apb(1'b1, 8'hd1, 8'hff);
		chk(32'(er), 32'h0);
		apb(1'b1, 8'h60, 8'hff);
		chk(32'(er), 32'h1);
		apb(1'b0, 8'h60, 8'h00);
		chk({rd[30:0], er}, 32'h1);
		// A write with byte lane 0 off must leave the register alone
		pstrb <= 4'h0;
		apb(1'b1, 8'h54, 8'h5a);
		pstrb <= 4'h1;
		apb(1'b0, 8'h54, 8'h00);
		chk(rd, 32'(mdl[8'h54]));
		// band codes for a 10 MHz detector, 40 MHz reference
		foreach (cfg[k]) apb(1'b1, cfg[k], 8'h00);
		apb(1'b1, 8'h54, 8'h04);
		apb(1'b1, 8'h55, 8'hf0);
		apb(1'b1, 8'h56, 8'h78);
		apb(1'b1, 8'h58, 8'h04);
		apb(1'b1, 8'h5a, 8'h1f);
		apb(1'b1, 8'h5b, 8'h02);
		apb(1'b1, 8'h5c, 8'h01);
		apb(1'b1, 8'h5d, 8'h01);
		apb(1'b1, 8'he1, 8'h01);
		ports_chk;
		chk(32'(40 * int'(feedback_divider) / int'(reference_divider)), 32'd1200);
		// Detector at 10 MHz sits inside its legal band
		chk(32'(40 / int'(reference_divider)), 32'd10);
		apb(1'b1, 8'h6b, 8'h01);
		cal_chk;
		apb(1'b1, 8'h6b, 8'h01);
		repeat (4) @(posedge pclk);
		#1;
		chk(32'(cal_run), 32'h0);
		for (int b = 1; b < 3; b++) begin
			apb(1'b1, 8'he1, 8'h01);
			low_req <= (b == 1);
			high_req <= (b == 2);
			repeat (5) @(posedge pclk);
			apb(1'b0, 8'hd1, 8'h00);
			chk(32'(rd[2:1]), 32'(b));
			#1;
			chk(32'(irq), 32'h0);
			apb(1'b1, 8'he1, 8'h07);
			#1;
			chk(32'(irq), 32'h1);
			apb(1'b0, 8'he0, 8'h00);
			chk(rd, 32'(1 << b));
			#1;
			chk(32'(irq), 32'h0);
		end
		finish_test;
	end
endmodule
`default_nettype wire
